// [hdl/tccu_pkg.sv]
package tccu_pkg;
  // ****************************************
  // Register map (byte addresses, 32-bit words)
  // ****************************************
  localparam logic [5:0] ADDR_CTRL_ONE = 6'h00;
  localparam logic [5:0] ADDR_CTRL_TWO = 6'h04;
  localparam logic [5:0] ADDR_STATUS = 6'h08;
  localparam logic [5:0] ADDR_CAP1_HI = 6'h0c;
  localparam logic [5:0] ADDR_CAP1_LO = 6'h10;
  localparam logic [5:0] ADDR_CAP2_HI = 6'h14;
  localparam logic [5:0] ADDR_CAP2_LO = 6'h18;
  localparam logic [5:0] ADDR_CMP1_HI = 6'h1c;
  localparam logic [5:0] ADDR_CMP1_LO = 6'h20;
  localparam logic [5:0] ADDR_CMP2_HI = 6'h24;
  localparam logic [5:0] ADDR_CMP2_LO = 6'h28;
  localparam logic [5:0] ADDR_CNT_HI = 6'h2c;
  localparam logic [5:0] ADDR_CNT_LO = 6'h30;
  localparam logic [5:0] ADDR_ACNT_HI = 6'h34;
  localparam logic [5:0] ADDR_ACNT_LO = 6'h38;
  // ****************************************
  // Control one fields
  // ****************************************
  localparam int C1_EDGE1 = 1;
  localparam int C1_OLVL1 = 0;
  localparam int C1_OLVL2 = 2;
  localparam int C1_FOLV1 = 3;
  localparam int C1_FOLV2 = 4;
  localparam int C1_TOIE = 5;
  localparam int C1_COMPARE_IRQ_ENABLE = 6;
  localparam int C1_CAPTURE_IRQ_ENABLE = 7;
  // ****************************************
  // Control two fields
  // ****************************************
  localparam int C2_EDGE2 = 0;
  localparam int C2_EXEDG = 1;
  localparam int C2_CS_LO = 2;
  localparam int C2_CS_HI = 3;
  localparam int C2_PWM = 4;
  localparam int C2_OPM = 5;
  localparam int C2_OE2 = 6;
  localparam int C2_OE1 = 7;
  // ****************************************
  // Status fields
  // ****************************************
  localparam int ST_TOF = 5;
  localparam int ST_OCF2 = 3;
  localparam int ST_ICF2 = 4;
  localparam int ST_OCF1 = 6;
  localparam int ST_ICF1 = 7;
  // ****************************************
  // Reset values and clock selection codes
  // ****************************************
  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CNT_RELOAD = 16'hfffc;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] CS_DIV2 = 2'h0;
  localparam logic [1:0] CS_DIV4 = 2'h1;
  localparam logic [1:0] CS_DIV8 = 2'h2;
  localparam logic [1:0] CS_EXT = 2'h3;
endpackage : tccu_pkg

// [hdl/tccu_top.sv]
// Contract
// RULE_01 - Two 16-bit captures latch counter on edge
// RULE_02 - Capture registers read-only, high/low bytes
// RULE_03 - Edge select bit picks rising or falling
// RULE_04 - Capture sets flag, gated interrupt request
// RULE_05 - Capture flag clears: status read, low access
// RULE_06 - High byte read blocks capture until low
// RULE_07 - Capture register holds most recent event
// RULE_08 - Captures and compares usable together
// RULE_09 - Single-shot/PWM: only capture two works
// RULE_10 - Any qualifying pin edge captures unless blocked
// RULE_11 - Software counts overflows for long spans
// RULE_12 - Two compares checked every timer clock
// RULE_13 - Compare registers RW, reset to 8000h
// RULE_14 - Match sets flag, drives level, interrupt
// RULE_15 - Compare pin latch low during reset
// RULE_16 - Compare flag clears: status read, low access
// RULE_17 - High write inhibits compare until low write
// RULE_18 - Software updates high, status, then low
// RULE_19 - Output disabled: no pin drive, flag stays
// RULE_20 - Div2 match at value, else value plus one
// RULE_21 - Counter advances at cpu clock div 2/4/8
// RULE_22 - Force bit copies level without flag
// RULE_23 - Force bits ignored in single-shot/PWM
// RULE_24 - Counter resets/reloads FFFCh on low write
// RULE_25 - Clock select 11 picks synced external clock
// RULE_26 - Capture pins synchronised before edge detect
`timescale 1ns/1ps
`default_nettype none
module tccu_top (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic global_mask_i,
  input wire logic capture_pin_one_i,
  input wire logic capture_pin_two_i,
  input wire logic external_timer_clock_pin_i,
  output logic compare_output_pin_one_o,
  output logic compare_output_pin_two_o,
  output logic compare_output_enable_one_o,
  output logic compare_output_enable_two_o,
  output logic timer_irq_o
);
  import tccu_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  // Control, counter and per-channel state
  // Byte-wide registers, as software sees them
  // Armed bits remember a status read per flag
  // Blocked and inhibit bits hold off one channel
  // Counter low byte buffer for split reads
  logic [7:0] timer_control_one;
  logic [7:0] timer_control_two;
  logic [15:0] counter;
  logic [2:0] presc;
  logic [15:0] capture_one_value;
  logic [15:0] capture_two_value;
  logic [15:0] compare_one_value;
  logic [15:0] compare_two_value;
  logic [1:0] capture_flag;
  logic [1:0] compare_flag;
  logic overflow_flag;
  logic [1:0] cap_armed;
  logic [1:0] cmp_armed;
  logic ovf_armed;
  logic [1:0] cap_blocked;
  logic [1:0] cmp_inhibit;
  logic [7:0] cnt_lo_buf;
  logic cnt_lo_held;
  logic [2:0] icap_s1, icap_s2, icap_s3;
  logic [1:0] pin_lvl;

  // ****************************************
  // Bus decode
  // ****************************************
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_sel_i[0];
  wire wr = bus_req & wb_we_i;
  wire rd = bus_req & ~wb_we_i;
  wire hit_c1 = wb_adr_i == ADDR_CTRL_ONE;
  wire hit_c2 = wb_adr_i == ADDR_CTRL_TWO;
  wire hit_st = wb_adr_i == ADDR_STATUS;
  wire hit_cap1h = wb_adr_i == ADDR_CAP1_HI;
  wire hit_cap1l = wb_adr_i == ADDR_CAP1_LO;
  wire hit_cap2h = wb_adr_i == ADDR_CAP2_HI;
  wire hit_cap2l = wb_adr_i == ADDR_CAP2_LO;
  wire hit_cmp1h = wb_adr_i == ADDR_CMP1_HI;
  wire hit_cmp1l = wb_adr_i == ADDR_CMP1_LO;
  wire hit_cmp2h = wb_adr_i == ADDR_CMP2_HI;
  wire hit_cmp2l = wb_adr_i == ADDR_CMP2_LO;
  wire hit_cnth = wb_adr_i == ADDR_CNT_HI;
  wire hit_cntl = wb_adr_i == ADDR_CNT_LO;
  wire hit_acnth = wb_adr_i == ADDR_ACNT_HI;
  wire hit_acntl = wb_adr_i == ADDR_ACNT_LO;
  wire [7:0] wbyte = wb_dat_i[7:0];
  // Only the low data lane carries a register
  // Lane select off: answered, nothing changes
  // Request seen once, in the cycle before ack
  // Unmapped offsets read zero, writes dropped
  // Full compare on six bits keeps decode simple

  // ****************************************
  // Modes and timer clock
  // ****************************************
  wire pwm_on = timer_control_two[C2_PWM];
  wire opm_on = timer_control_two[C2_OPM] & ~pwm_on;
  wire special = pwm_on | opm_on;
  wire [1:0] clock_select_field = timer_control_two[C2_CS_HI:C2_CS_LO];
  // Level from the pin after two flops; third flop only for edge detect
  wire ext_edge = timer_control_two[C2_EXEDG] ? (icap_s2[2] & ~icap_s3[2]) : (~icap_s2[2] & icap_s3[2]);
  // Timer clock is a one-cycle enable, not a clock
  // Keeps the whole block in one domain
  // External rate must stay under a quarter
  // of the cpu clock or edges are lost
  logic tick;
  always_comb begin
    case (clock_select_field)
      CS_DIV2: tick = presc[0];
      CS_DIV4: tick = presc[1:0] == 2'h3;
      CS_DIV8: tick = presc == 3'h7;
      default: tick = ext_edge; // RULE_25
    endcase
  end
  wire [15:0] next_counter = counter + 16'h0001;
  wire overflow = tick & (counter == 16'hffff);
  // Overflow marks the roll from top to zero
  // Software counts these for spans past range
  // Flag set wins over a clear in the same cycle
  // No request unless its enable bit is set

  // ****************************************
  // Capture detection
  // ****************************************
  wire [1:0] pin_rise = icap_s2[1:0] & ~icap_s3[1:0];
  wire [1:0] pin_fall = ~icap_s2[1:0] & icap_s3[1:0];
  // Edge select high means rising edge
  // Both channels built alike, bit per channel
  // A pin toggled as output still captures
  // Detect runs on synced levels only
  wire [1:0] edge_sel = {timer_control_two[C2_EDGE2], timer_control_one[C1_EDGE1]};
  wire [1:0] pin_edge = (edge_sel & pin_rise) | (~edge_sel & pin_fall); // RULE_03 RULE_10
  // First channel serves the special modes and never captures there
  wire [1:0] cap_event = pin_edge & ~cap_blocked & {1'b1, ~special}; // RULE_06 RULE_09 RULE_08

  // ****************************************
  // Compare detection
  // ****************************************
  // Slower clocks see the match one count late, as the counter had moved on
  wire [15:0] cmp_target1 = (clock_select_field == CS_DIV2) ? compare_one_value : compare_one_value + 16'h0001;
  wire [15:0] cmp_target2 = (clock_select_field == CS_DIV2) ? compare_two_value : compare_two_value + 16'h0001;
  // Counter copy from the previous cycle
  // Match fires only when the count moves in
  // Otherwise a slow timer clock would repeat
  // the flag for every cpu cycle at that count
  // Reload also counts as a move into a value
  logic [15:0] prev_cnt;
  wire cnt_moved = prev_cnt != counter;
  // Fire once per entry into the matching count
  wire [1:0] cmp_event = {cnt_moved & (counter == cmp_target2), cnt_moved & (counter == cmp_target1)}
                         & ~cmp_inhibit; // RULE_12 RULE_20 RULE_17
  // Flags one and two stay quiet in pwm
  // Single shot still lets flag two set
  // Pin path below keeps its own enable
  wire [1:0] cmp_flag_set = cmp_event & {~pwm_on, ~special};
  wire [1:0] olvl = {timer_control_one[C1_OLVL2], timer_control_one[C1_OLVL1]};
  wire [1:0] oe = {timer_control_two[C2_OE2], timer_control_two[C2_OE1]};
  wire [1:0] force_hit = {timer_control_one[C1_FOLV2], timer_control_one[C1_FOLV1]} & {2{~special}}; // RULE_23

  // ****************************************
  // Flag clearing arms on a status read
  // ****************************************
  // Two step clear: status read, then low byte
  // Arm holds what was set at the status read
  // A flag set later is not cleared by mistake
  // Low byte read or write both count as access
  // Alternate counter low never clears overflow
  wire st_read = rd & hit_st;
  wire [1:0] cap_lo_acc = {bus_req & hit_cap2l, bus_req & hit_cap1l};
  wire [1:0] cmp_lo_acc = {bus_req & hit_cmp2l, bus_req & hit_cmp1l};
  wire cnt_lo_acc = bus_req & hit_cntl;

  // ****************************************
  // Prescaler and counter
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      presc <= 3'h0;
      counter <= CNT_RELOAD; // RULE_24
      prev_cnt <= CNT_RELOAD;
    end else begin
      // Prescaler free runs; taps pick the rate
      // Low counter write restarts both, so the
      // first count after reload is a full period
      // Counter never stalls for bus traffic
      presc <= presc + 3'h1; // RULE_21
      prev_cnt <= counter;
      if (wr & (hit_cntl | hit_acntl)) begin
        presc <= 3'h0;
        counter <= CNT_RELOAD; // RULE_24
      end else if (tick) begin
        counter <= next_counter;
      end
    end
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      icap_s1 <= 3'h0;
      icap_s2 <= 3'h0;
      icap_s3 <= 3'h0;
    end else begin
      icap_s1 <= {external_timer_clock_pin_i, capture_pin_two_i, capture_pin_one_i}; // RULE_26
      // Second stage settles any metastable first
      // Nothing else may read the first stage
      // Third stage only serves edge detection
      // Costs two cycles of capture latency
      icap_s2 <= icap_s1;
      icap_s3 <= icap_s2;
    end
  end

  // ****************************************
  // Capture values, flags and blocking
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      capture_one_value <= 16'h0000;
      capture_two_value <= 16'h0000;
      capture_flag <= 2'h0;
      cap_armed <= 2'h0;
      cap_blocked <= 2'h0;
    end else begin
      if (cap_event[0]) capture_one_value <= counter; // RULE_01 RULE_07
      if (cap_event[1]) capture_two_value <= counter; // RULE_01 RULE_07
      if (st_read) cap_armed <= capture_flag;
      // Clear needs arm then low access; new capture wins over clear
      capture_flag <= (capture_flag & ~(cap_armed & cap_lo_acc)) | cap_event; // RULE_04 RULE_05
      cap_armed <= (st_read ? capture_flag : cap_armed) & ~cap_lo_acc;
      // High byte read freezes the channel so
      // the low byte still pairs with the high
      // Only a low byte read lets it go again
      // A write to the low byte does not unblock
      // Edges while frozen are lost, not queued
      if (rd & hit_cap1h) cap_blocked[0] <= 1'b1; // RULE_06
      if (rd & hit_cap2h) cap_blocked[1] <= 1'b1; // RULE_06
      if (rd & hit_cap1l) cap_blocked[0] <= 1'b0;
      if (rd & hit_cap2l) cap_blocked[1] <= 1'b0;
    end
  end

  // ****************************************
  // Compare values, flags, overflow
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      compare_one_value <= CMP_RESET; // RULE_13
      compare_two_value <= CMP_RESET; // RULE_13
      compare_flag <= 2'h0;
      cmp_armed <= 2'h0;
      cmp_inhibit <= 2'h0;
      overflow_flag <= 1'b0;
      ovf_armed <= 1'b0;
    end else begin
      if (wr & hit_cmp1h) compare_one_value[15:8] <= wbyte;
      if (wr & hit_cmp1l) compare_one_value[7:0] <= wbyte;
      if (wr & hit_cmp2h) compare_two_value[15:8] <= wbyte;
      if (wr & hit_cmp2l) compare_two_value[7:0] <= wbyte;
      cmp_inhibit <= (cmp_inhibit | {wr & hit_cmp2h, wr & hit_cmp1h})
                     & ~{wr & hit_cmp2l, wr & hit_cmp1l}; // RULE_17
      compare_flag <= (compare_flag & ~(cmp_armed & cmp_lo_acc)) | cmp_flag_set; // RULE_14 RULE_16
      cmp_armed <= (st_read ? compare_flag : cmp_armed) & ~cmp_lo_acc;
      // Overflow flag follows the same two steps
      // Only the plain counter low byte clears it
      // so the alternate pair can be read freely
      // while overflow interrupts are counted
      overflow_flag <= (overflow_flag & ~(ovf_armed & cnt_lo_acc)) | overflow;
      ovf_armed <= (st_read ? overflow_flag : ovf_armed) & ~cnt_lo_acc;
    end
  end

  // ****************************************
  // Compare output latches
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_lvl <= 2'h0; // RULE_15
      compare_output_pin_one_o <= 1'b0;
      compare_output_pin_two_o <= 1'b0;
      compare_output_enable_one_o <= 1'b0;
      compare_output_enable_two_o <= 1'b0;
    end else begin
      // Force path sets no flag and raises no request
      for (int i = 0; i < 2; i++) begin
        if ((cmp_event[i] & oe[i]) | force_hit[i]) pin_lvl[i] <= olvl[i]; // RULE_14 RULE_19 RULE_22
      end
      // Pin latch copied to the port flop
      // One extra cycle, but the port is glitch free
      // Enable follows its control bit
      // Latch ignores matches while not enabled; a set force bit still loads it
      compare_output_pin_one_o <= pin_lvl[0];
      compare_output_pin_two_o <= pin_lvl[1];
      compare_output_enable_one_o <= oe[0]; // RULE_19
      compare_output_enable_two_o <= oe[1];
    end
  end

  // ****************************************
  // Control registers, counter read buffer, bus answer
  // ****************************************
  // Read mux for the addressed byte
  // Capture bytes are read only; writes ignored
  // Counter low comes from the buffer while held
  // so a split read sees one consistent count
  // Status bits not used read as zero
  logic [7:0] rbyte;
  always_comb begin
    rbyte = 8'h00;
    if (hit_c1) rbyte = timer_control_one;
    if (hit_c2) rbyte = timer_control_two;
    if (hit_st) rbyte = {capture_flag[0], compare_flag[0], overflow_flag, capture_flag[1], compare_flag[1], 3'h0};
    if (hit_cap1h) rbyte = capture_one_value[15:8]; // RULE_02
    if (hit_cap1l) rbyte = capture_one_value[7:0];
    if (hit_cap2h) rbyte = capture_two_value[15:8];
    if (hit_cap2l) rbyte = capture_two_value[7:0];
    if (hit_cmp1h) rbyte = compare_one_value[15:8];
    if (hit_cmp1l) rbyte = compare_one_value[7:0];
    if (hit_cmp2h) rbyte = compare_two_value[15:8];
    if (hit_cmp2l) rbyte = compare_two_value[7:0];
    if (hit_cnth | hit_acnth) rbyte = counter[15:8];
    if (hit_cntl | hit_acntl) rbyte = cnt_lo_held ? cnt_lo_buf : counter[7:0];
  end
  // One request line for all timer sources
  // Shared enable covers both capture channels
  // Masked requests stay pending in the flags
  // Drops only when flags clear, enables drop or the global mask rises
  wire irq_pend = (timer_control_one[C1_CAPTURE_IRQ_ENABLE] & |capture_flag) | (timer_control_one[C1_COMPARE_IRQ_ENABLE] & |compare_flag)
                  | (timer_control_one[C1_TOIE] & overflow_flag);
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      timer_control_one <= CTRL_RESET;
      timer_control_two <= CTRL_RESET;
      cnt_lo_buf <= 8'h00;
      cnt_lo_held <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      timer_irq_o <= 1'b0;
    end else begin
      if (wr & hit_c1) timer_control_one <= wbyte;
      if (wr & hit_c2) timer_control_two <= wbyte;
      if (rd & (hit_cnth | hit_acnth) & ~cnt_lo_held) begin
        cnt_lo_buf <= counter[7:0];
        cnt_lo_held <= 1'b1;
      end
      if (rd & (hit_cntl | hit_acntl)) cnt_lo_held <= 1'b0;
      // Ack one cycle after the request, one wide
      // Data register loads every cycle; it only
      // counts in the cycle that ack stands
      // Master must drop the strobe before a new one
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= {24'h000000, rbyte};
      // Flags stay pending while masked
      timer_irq_o <= irq_pend & ~global_mask_i; // RULE_04 RULE_14
    end
  end
endmodule : tccu_top
`default_nettype wire

// [tb/tccu_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module tccu_checker (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic global_mask_i,
  input wire logic compare_output_pin_one_o,
  input wire logic compare_output_pin_two_o,
  input wire logic compare_output_enable_one_o,
  input wire logic compare_output_enable_two_o,
  input wire logic timer_irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // Bus answers: one cycle late, one cycle wide
  ack_one_wide_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too wide");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  dat_upper_a: assert property (wb_dat_o[31:8] == 24'h0) else $error("read data upper bits set");
  // Latch must be low while reset holds, so no disable here
  pin_reset_low_a: assert property (disable iff (1'b0)
    !resetn_i && $past(!resetn_i) |-> !compare_output_pin_one_o && !compare_output_pin_two_o)
    else $error("pin high in reset");
  mask_blocks_a: assert property (global_mask_i |=> !timer_irq_o) else $error("irq while masked");
  // Flags only clear through a bus access, so irq may only drop after one or while the global mask is set
  irq_hold_a: assert property ($fell(timer_irq_o) |->
    $past(global_mask_i) || $past(wb_ack_o) || $past(wb_ack_o, 2)) else $error("irq dropped alone");
  oe_write_cause_a: assert property (
    $changed({compare_output_enable_one_o, compare_output_enable_two_o}) |->
    (wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i)) else $error("enable changed without write");
endmodule : tccu_checker
`default_nettype wire

// [tb/tccu_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Far-side pin driver
// ****************************************
module tccu_pin_model (
  output var logic capture_pin_one_o,
  output var logic capture_pin_two_o,
  output var logic external_timer_clock_pin_o
);
  // Pins idle low; clock stands still outside bursts
  initial begin
    capture_pin_one_o = 1'b0;
    capture_pin_two_o = 1'b0;
    external_timer_clock_pin_o = 1'b0;
  end
  // Off-edge delay so the edge lands unrelated to the cpu clock
  task automatic set_pin(input int ch, input logic lvl);
    #7;
    if (ch == 1) capture_pin_one_o = lvl;
    else capture_pin_two_o = lvl;
  endtask : set_pin
  // Period 160 ns: well under a quarter of the cpu clock rate
  task automatic ext_pulses(input int n);
    repeat (n) begin
      #80 external_timer_clock_pin_o = 1'b1;
      #80 external_timer_clock_pin_o = 1'b0;
    end
  endtask : ext_pulses
endmodule : tccu_pin_model
`default_nettype wire

// [tb/test_timer_capture_compare_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module test_timer_capture_compare_unit;
  import tccu_pkg::*;
  logic mclk_i = 1'b0, resetn_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, global_mask_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, cap1, cap2, external_timer_clock_pin, pin1, pin2, oe1, oe2, timer_irq_o;
  logic [15:0] v, w;
  int err_total = 0, check_count = 0;
  initial forever #10 mclk_i = ~mclk_i;
  tccu_top tccu_top_inst (.mclk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .global_mask_i, .capture_pin_one_i(cap1), .capture_pin_two_i(cap2),
    .external_timer_clock_pin_i(external_timer_clock_pin), .compare_output_pin_one_o(pin1), .compare_output_pin_two_o(pin2),
    .compare_output_enable_one_o(oe1), .compare_output_enable_two_o(oe2), .timer_irq_o);
  tccu_pin_model tccu_pin_model_inst (.capture_pin_one_o(cap1), .capture_pin_two_o(cap2),
    .external_timer_clock_pin_o(external_timer_clock_pin));
  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task automatic wb(input logic [5:0] a, input logic we, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge mclk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // High byte first, as capture and counter reads need
  task automatic rd16(input logic [5:0] hi, output logic [15:0] r);
    wb(hi, 1'b0, 8'h0);
    r[15:8] = rd[7:0];
    wb(hi + 6'h4, 1'b0, 8'h0);
    r[7:0] = rd[7:0];
  endtask : rd16
  task automatic st(input int b, input logic e);
    wb(ADDR_STATUS, 1'b0, 8'h0);
    chk("status bit", {15'h0, e}, {15'h0, rd[b]});
  endtask : st
  task automatic pins(input logic ch, input logic lvl);
    tccu_pin_model_inst.set_pin(ch ? 2 : 1, lvl);
    repeat (8) @(posedge mclk_i);
  endtask : pins
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    rd16(ADDR_CMP1_HI, v);
    chk("compare one", CMP_RESET, v);
    rd16(ADDR_CMP2_HI, v);
    chk("compare two", CMP_RESET, v);
    wb(ADDR_CMP2_HI, 1'b1, 8'h12);
    wb(ADDR_CMP2_LO, 1'b1, 8'h34);
    rd16(ADDR_CMP2_HI, v);
    chk("compare two", 16'h1234, v);
    wb(6'h3c, 1'b1, 8'hff);
    wb(6'h3c, 1'b0, 8'h0);
    chk("unmapped", 16'h0, rd[15:0]);
    rd16(ADDR_CAP1_HI, v);
    wb(ADDR_CAP1_HI, 1'b1, 8'ha5);
    rd16(ADDR_CAP1_HI, w);
    chk("capture one", v, w);
  endtask : t_regs
  task automatic t_capture;
    wb(ADDR_CTRL_TWO, 1'b1, 8'h00);
    wb(ADDR_CTRL_ONE, 1'b1, 8'h82);
    rd16(ADDR_CNT_HI, w);
    pins(0, 1'b1);
    chk("irq", 16'h1, {15'h0, timer_irq_o});
    st(ST_ICF1, 1'b1);
    rd16(ADDR_CAP1_HI, v);
    chk("capture span", 16'h1, {15'h0, (v - w) < 16'h20});
    st(ST_ICF1, 1'b0);
    global_mask_i <= 1'b1;
    pins(1, 1'b1);
    st(ST_ICF2, 1'b0);
    pins(1, 1'b0);
    st(ST_ICF2, 1'b1);
    chk("irq masked", 16'h0, {15'h0, timer_irq_o});
    global_mask_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk("irq pending", 16'h1, {15'h0, timer_irq_o});
    rd16(ADDR_CAP2_HI, w);
    wb(ADDR_CAP1_HI, 1'b0, 8'h0);
    pins(0, 1'b0);
    pins(0, 1'b1);
    st(ST_ICF1, 1'b0);
    wb(ADDR_CAP1_LO, 1'b0, 8'h0);
    chk("blocked capture", v[7:0], rd[15:0]);
    pins(0, 1'b0);
    pins(0, 1'b1);
    rd16(ADDR_CAP1_HI, w);
    chk("newest capture", 16'h1, {15'h0, (w - v - 16'h1) < 16'h40});
  endtask : t_capture
  task automatic t_compare;
    wb(ADDR_CTRL_TWO, 1'b1, 8'h80);
    wb(ADDR_CTRL_ONE, 1'b1, 8'h41);
    wb(ADDR_CMP1_HI, 1'b1, 8'h00);
    wb(ADDR_STATUS, 1'b0, 8'h0);
    wb(ADDR_CMP1_LO, 1'b1, 8'h20);
    wb(ADDR_CNT_LO, 1'b1, 8'h0);
    repeat (30) @(posedge mclk_i);
    chk("pin early", 16'h0, {15'h0, pin1});
    for (int n = 0; n < 200 && pin1 !== 1'b1; n++) @(posedge mclk_i);
    rd16(ADDR_CNT_HI, v);
    chk("match count", 16'h1, {15'h0, (v - 16'h20) < 16'h4});
    chk("pin driven", 16'h3, {14'h0, pin1, oe1});
    chk("irq", 16'h1, {15'h0, timer_irq_o});
    st(ST_OCF1, 1'b1);
    wb(ADDR_CMP1_LO, 1'b1, 8'h20);
    st(ST_OCF1, 1'b0);
    wb(ADDR_CMP1_HI, 1'b1, 8'h00);
    wb(ADDR_CNT_LO, 1'b1, 8'h0);
    repeat (100) @(posedge mclk_i);
    st(ST_OCF1, 1'b0);
    wb(ADDR_CMP1_LO, 1'b1, 8'h20);
    wb(ADDR_CTRL_TWO, 1'b1, 8'h00);
    wb(ADDR_CTRL_ONE, 1'b1, 8'h40);
    wb(ADDR_CNT_LO, 1'b1, 8'h0);
    repeat (100) @(posedge mclk_i);
    chk("pin idle", 16'h2, {14'h0, pin1, oe1});
    st(ST_OCF1, 1'b1);
    wb(ADDR_CMP1_LO, 1'b1, 8'h20);
  endtask : t_compare
  task automatic t_force;
    wb(ADDR_CTRL_TWO, 1'b1, 8'h80);
    wb(ADDR_CTRL_ONE, 1'b1, 8'h08);
    repeat (3) @(posedge mclk_i);
    chk("forced low", 16'h0, {15'h0, pin1});
    wb(ADDR_CTRL_ONE, 1'b1, 8'h09);
    repeat (3) @(posedge mclk_i);
    chk("forced high", 16'h1, {15'h0, pin1});
    wb(ADDR_CTRL_TWO, 1'b1, 8'hc0);
    wb(ADDR_CTRL_ONE, 1'b1, 8'h1d);
    repeat (3) @(posedge mclk_i);
    chk("both forced", 16'h000f, {12'h0, pin1, pin2, oe1, oe2});
    st(ST_OCF1, 1'b0);
    wb(ADDR_CTRL_TWO, 1'b1, 8'ha0);
    wb(ADDR_CTRL_ONE, 1'b1, 8'h08);
    repeat (3) @(posedge mclk_i);
    chk("force in single shot", 16'h1, {15'h0, pin1});
  endtask : t_force
  task automatic t_ext;
    wb(ADDR_CTRL_TWO, 1'b1, 8'h0e);
    st(ST_TOF, 1'b1);
    wb(ADDR_CNT_LO, 1'b1, 8'h0);
    st(ST_TOF, 1'b0);
    tccu_pin_model_inst.ext_pulses(6);
    repeat (8) @(posedge mclk_i);
    st(ST_TOF, 1'b1);
    rd16(ADDR_CNT_HI, v);
    chk("external count", 16'h0002, v);
  endtask : t_ext
  task automatic results;
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_total++;
    results();
  end
  initial begin
    repeat (6) @(posedge mclk_i);
    chk("pin in reset", 16'h0, {14'h0, pin1, pin2});
    resetn_i <= 1'b1;
    t_regs();
    t_capture();
    t_compare();
    t_force();
    t_ext();
    results();
  end
endmodule : test_timer_capture_compare_unit
bind tccu_top tccu_checker tccu_checker_inst (.mclk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_dat_o, .wb_ack_o, .global_mask_i, .compare_output_pin_one_o, .compare_output_pin_two_o,
  .compare_output_enable_one_o, .compare_output_enable_two_o, .timer_irq_o);
`default_nettype wire
